// File: hdl/ivt_pkg.sv
// constants and types for the interrupt vector and trap dispatcher
// ----------------------------------------------------------------
// How it works
// - each node owns fixed trap number and slot
// - vector segment comes from segment register
// - spacing code scales offset per trap number
// - default spacing: offset equals trap times four
// - without second serial, its nodes are unassigned
// - hardware trap branches unmasked to its trap vector, traps 4 to 7 share 0x0A
// - hardware trap sets its own flag bit
// - trap waits only behind a trap of higher or equal priority in service
// - trap service blocks interrupts and transfers
// - node control holds request, enable, level
// - only strictly higher level preempts service
// - software request bit raises node request
// - node may route to event transfer channel
// ----------------------------------------------------------------
package ivt_pkg;

    localparam int IVT_NODES = 128;
    localparam int IVT_TRAPS = 8;
    localparam int IVT_CHANS = 8;
    localparam int IVT_LVL_W = 4;
    localparam int IVT_CNT_W = 8;

    localparam logic [6:0] IVT_NODE_FIRST = 7'h10;
    localparam logic [6:0] IVT_NODE_LAST = 7'h5F;

    // register byte offsets
    localparam logic [11:0] IVT_ADR_SEG = 12'h000;
    localparam logic [11:0] IVT_ADR_CFG = 12'h004;
    localparam logic [11:0] IVT_ADR_TFLAG = 12'h008;
    localparam logic [11:0] IVT_ADR_STAT = 12'h00C;
    localparam logic [11:0] IVT_ADR_MASK = 12'h010;
    localparam logic [6:0] IVT_ADR_XFER_TAG = 7'h01;
    localparam logic [2:0] IVT_ADR_NODE_TAG = 3'h1;

    // reset values and slot shift
    localparam logic [7:0] IVT_SEG_RST = 8'h00;
    localparam logic [1:0] IVT_SPC_RST = 2'h0;
    localparam logic [1:0] IVT_SLOT_SHIFT = 2'h2;

    // interrupt status bits
    localparam int IVT_EV_W = 3;
    localparam int IVT_EV_TRAP = 0;
    localparam int IVT_EV_XFER = 1;
    localparam int IVT_EV_TAKE = 2;

    // hardware trap numbers, index order is priority order
    localparam logic [6:0] IVT_TRAP_NUM [IVT_TRAPS] = '{
        7'h02, 7'h04, 7'h06, 7'h08, 7'h0A, 7'h0A, 7'h0A, 7'h0A
    };

    typedef struct packed {
        logic [2:0] chan;
        logic xfer;
        logic req;
        logic en;
        logic [1:0] pad;
        logic [3:0] lvl;
    } ivt_node_t;

    typedef struct packed {
        logic irq;
        logic xfer;
        logic trap;
        logic [6:0] num;
        logic [2:0] chan;
        logic [23:0] addr;
    } ivt_grant_t;

    // nodes with no peripheral source behind them
    function automatic logic ivt_has_source(input logic [6:0] n, input logic asc);
        logic r;
        r = (n >= IVT_NODE_FIRST) && (n <= IVT_NODE_LAST);
        case (n)
            7'h3F, 7'h40, 7'h41, 7'h4B, 7'h54, 7'h55, 7'h56, 7'h57,
            7'h58, 7'h59, 7'h5A, 7'h5B, 7'h5C: r = 1'b0;
            7'h42, 7'h48, 7'h49, 7'h4A, 7'h5E: r = r && asc;
            default: r = r;
        endcase
        return r;
    endfunction

endpackage

// File: hdl/ivt_node_arbiter.sv
// picks the highest level requesting node, lowest index on ties
module ivt_node_arbiter #(
    parameter int N = 128,
    parameter int W = 4
) (
    input wire logic [N-1:0] req_i,
    input wire logic [N*W-1:0] lvl_i,
    output logic valid_o,
    output logic [$clog2(N)-1:0] idx_o,
    output logic [W-1:0] lvl_o
);
    generate
        if (N < 2 || W < 1) begin : g_bad
            $error("ivt_node_arbiter: N must be 2 or more, W 1 or more");
        end
    endgenerate

    // scan downward with >= so the lowest index wins a tie
    always_comb begin
        valid_o = 1'b0;
        idx_o = '0;
        lvl_o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i] && (!valid_o || lvl_i[i*W +: W] >= lvl_o)) begin
                valid_o = 1'b1;
                idx_o = ($clog2(N))'(i);
                lvl_o = lvl_i[i*W +: W];
            end
        end
    end
endmodule

// File: hdl/ivt_vector_addr.sv
// forms a vector address from segment, spacing code and trap number
module ivt_vector_addr
    import ivt_pkg::*;
(
    input wire logic [7:0] seg_i,
    input wire logic [1:0] spc_i,
    input wire logic [6:0] num_i,
    output logic [23:0] addr_o
);
    logic [2:0] shift;
    logic [15:0] offset;

    assign shift = {1'b0, spc_i} + {1'b0, IVT_SLOT_SHIFT};
    assign offset = 16'({9'h000, num_i} << shift);
    assign addr_o = {seg_i, offset};
endmodule

// File: hdl/ivt_dispatch.sv
// interrupt vector and hardware trap dispatcher with wishbone registers
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
module ivt_dispatch
    import ivt_pkg::*;
#(
    parameter bit HAS_SECOND_SERIAL = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [ivt_pkg::IVT_NODES-1:0] node_req_i,
    input wire logic [ivt_pkg::IVT_TRAPS-1:0] trap_cond_i,
    input wire logic [3:0] cpu_prio_i,
    input wire logic take_i,
    input wire logic trap_done_i,
    output ivt_pkg::ivt_grant_t grant_o,
    output logic irq_o
);
    import ivt_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ivt_node_t node_reg [IVT_NODES];
    ivt_node_t node_next [IVT_NODES];
    logic [IVT_CNT_W-1:0] cnt_reg [IVT_CHANS];
    logic [IVT_CNT_W-1:0] cnt_next [IVT_CHANS];
    logic [7:0] seg_reg;
    logic [1:0] spc_reg;
    logic [IVT_TRAPS-1:0] tflag_reg, tflag_next;
    logic [IVT_TRAPS-1:0] pend_reg, pend_next;
    logic [IVT_TRAPS-1:0] act_reg, act_next;
    logic [2:0] tidx_reg, tidx_next;
    logic [IVT_EV_W-1:0] stat_reg, stat_next, mask_reg;
    ivt_grant_t grant_reg, grant_next;
    logic ack_reg;
    logic [31:0] rdat_reg;

    function automatic logic [IVT_TRAPS-1:0] low_bit(input logic [IVT_TRAPS-1:0] x);
        return x & (~x + IVT_TRAPS'(1));
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] sel);
        logic [15:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire hit = wb_cyc_i && wb_stb_i && !ack_reg;
    wire wr = hit && wb_we_i;
    wire rd = hit && !wb_we_i;
    wire is_node = wb_adr_i[11:9] == IVT_ADR_NODE_TAG;
    wire [6:0] node_idx = wb_adr_i[8:2];
    wire is_xfer = wb_adr_i[11:5] == IVT_ADR_XFER_TAG;
    wire [2:0] xfer_idx = wb_adr_i[4:2];
    wire node_wr = wr && is_node;
    wire xfer_wr = wr && is_xfer;
    wire seg_wr = wr && wb_adr_i == IVT_ADR_SEG;
    wire cfg_wr = wr && wb_adr_i == IVT_ADR_CFG;
    wire tflag_wr = wr && wb_adr_i == IVT_ADR_TFLAG;
    wire mask_wr = wr && wb_adr_i == IVT_ADR_MASK;
    wire stat_rd = rd && wb_adr_i == IVT_ADR_STAT;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (is_node)
            rd_mux = {20'h00000, node_reg[node_idx]};
        else if (is_xfer)
            rd_mux = {24'h000000, cnt_reg[xfer_idx]};
        else begin
            case (wb_adr_i)
                IVT_ADR_SEG: rd_mux = {24'h000000, seg_reg};
                IVT_ADR_CFG: rd_mux = {30'h00000000, spc_reg};
                IVT_ADR_TFLAG: rd_mux = {24'h000000, tflag_reg};
                IVT_ADR_STAT: rd_mux = {29'h00000000, stat_reg};
                IVT_ADR_MASK: rd_mux = {29'h00000000, mask_reg};
                default: rd_mux = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // service handshake
    // ----------------------------------------------------------------
    wire grant_any = grant_reg.irq || grant_reg.xfer || grant_reg.trap;
    wire take_fire = take_i && grant_any;
    wire take_irq = take_fire && grant_reg.irq;
    wire take_xfer = take_fire && grant_reg.xfer;
    wire take_trap = take_fire && grant_reg.trap;
    wire [IVT_CNT_W-1:0] take_cnt = cnt_reg[grant_reg.chan];
    wire xfer_last = take_xfer && take_cnt == IVT_CNT_W'(1);
    wire trap_busy = |act_reg;

    // ----------------------------------------------------------------
    // node requests
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < IVT_NODES; i++) begin
            node_next[i] = node_reg[i];
            if (node_wr && node_idx == 7'(i))
                node_next[i] = ivt_node_t'(merge16(16'(node_reg[i]), wb_dat_i[15:0],
                                                   wb_sel_i[1:0]));
            if (grant_reg.num == 7'(i) && (take_irq || (take_xfer && !xfer_last)))
                node_next[i].req = 1'b0;
            if (node_req_i[i] && ivt_has_source(7'(i), HAS_SECOND_SERIAL))
                node_next[i].req = 1'b1;
            node_next[i].pad = 2'h0;
            if (7'(i) < IVT_NODE_FIRST || 7'(i) > IVT_NODE_LAST)
                node_next[i] = '0;
        end
        for (int c = 0; c < IVT_CHANS; c++) begin
            cnt_next[c] = cnt_reg[c];
            if (take_xfer && grant_reg.chan == 3'(c) && cnt_reg[c] != '0)
                cnt_next[c] = cnt_reg[c] - IVT_CNT_W'(1);
            if (xfer_wr && xfer_idx == 3'(c) && wb_sel_i[0])
                cnt_next[c] = wb_dat_i[IVT_CNT_W-1:0];
        end
    end

    logic [IVT_NODES-1:0] arb_req;
    logic [IVT_NODES*IVT_LVL_W-1:0] arb_lvl;
    always_comb begin
        for (int i = 0; i < IVT_NODES; i++) begin
            arb_req[i] = node_reg[i].req && node_reg[i].en && !trap_busy
                         && node_reg[i].lvl > cpu_prio_i;
            arb_lvl[i*IVT_LVL_W +: IVT_LVL_W] = node_reg[i].lvl;
        end
    end

    logic arb_valid;
    logic [6:0] arb_idx;
    ivt_node_arbiter #(
        .N(IVT_NODES),
        .W(IVT_LVL_W)
    ) u_arb (
        .req_i(arb_req),
        .lvl_i(arb_lvl),
        .valid_o(arb_valid),
        .idx_o(arb_idx),
        .lvl_o()
    );

    wire win_xfer = node_reg[arb_idx].xfer && cnt_reg[node_reg[arb_idx].chan] != '0;

    // ----------------------------------------------------------------
    // hardware traps
    // ----------------------------------------------------------------
    wire [IVT_TRAPS-1:0] act_low = low_bit(act_reg);
    wire [IVT_TRAPS-1:0] trap_elig = trap_busy ? pend_reg & (act_low - IVT_TRAPS'(1))
                                               : pend_reg;
    wire [IVT_TRAPS-1:0] trap_win = low_bit(trap_elig);
    logic [2:0] trap_idx;
    always_comb begin
        trap_idx = '0;
        for (int t = IVT_TRAPS - 1; t >= 0; t--)
            if (trap_win[t])
                trap_idx = 3'(t);
    end

    wire [IVT_TRAPS-1:0] taken_hot = take_trap ? IVT_TRAPS'(1) << tidx_reg : '0;
    assign pend_next = (pend_reg & ~taken_hot) | trap_cond_i;
    assign tflag_next = (tflag_wr && wb_sel_i[0] ? wb_dat_i[7:0] & tflag_reg : tflag_reg)
                      | trap_cond_i;
    assign act_next = (trap_done_i ? act_reg & ~act_low : act_reg) | taken_hot;

    // ----------------------------------------------------------------
    // vector selection
    // ----------------------------------------------------------------
    logic [23:0] vec_addr;
    wire [6:0] sel_num = |trap_elig ? IVT_TRAP_NUM[trap_idx] : arb_idx;
    ivt_vector_addr u_vec (
        .seg_i(seg_reg),
        .spc_i(spc_reg),
        .num_i(sel_num),
        .addr_o(vec_addr)
    );

    always_comb begin
        grant_next = '0;
        tidx_next = tidx_reg;
        if (!take_fire) begin
            grant_next.num = sel_num;
            grant_next.addr = vec_addr;
            if (|trap_elig) begin
                grant_next.trap = 1'b1;
                tidx_next = trap_idx;
            end else if (arb_valid) begin
                grant_next.xfer = win_xfer;
                grant_next.irq = !win_xfer;
                grant_next.chan = node_reg[arb_idx].chan;
            end else begin
                grant_next.num = '0;
                grant_next.addr = '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status
    // ----------------------------------------------------------------
    wire [IVT_EV_W-1:0] events = {take_fire, xfer_last, |trap_cond_i};
    assign stat_next = (stat_rd ? '0 : stat_reg) | events;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        node_reg <= node_next;
        cnt_reg <= cnt_next;
        if (rst_i) begin
            node_reg <= '{default: '0};
            cnt_reg <= '{default: '0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seg_reg <= IVT_SEG_RST;
            spc_reg <= IVT_SPC_RST;
            mask_reg <= '0;
        end else begin
            if (seg_wr && wb_sel_i[0])
                seg_reg <= wb_dat_i[7:0];
            if (cfg_wr && wb_sel_i[0])
                spc_reg <= wb_dat_i[1:0];
            if (mask_wr && wb_sel_i[0])
                mask_reg <= wb_dat_i[IVT_EV_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tflag_reg <= '0;
            pend_reg <= '0;
            act_reg <= '0;
            tidx_reg <= '0;
            stat_reg <= '0;
            grant_reg <= '0;
        end else begin
            tflag_reg <= tflag_next;
            pend_reg <= pend_next;
            act_reg <= act_next;
            tidx_reg <= tidx_next;
            stat_reg <= stat_next;
            grant_reg <= grant_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
            irq_o <= 1'b0;
        end else begin
            ack_reg <= hit;
            rdat_reg <= rd ? rd_mux : '0;
            irq_o <= |(stat_reg & mask_reg);
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign grant_o = grant_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_fixed_slot;
        grant_reg.irq |-> grant_reg.num >= IVT_NODE_FIRST && grant_reg.num <= IVT_NODE_LAST;
    endproperty
    a_fixed_slot: assert property (p_fixed_slot) else $error("node slot out of range");

    property p_seg;
        grant_any && $stable(seg_reg) |-> grant_reg.addr[23:16] == seg_reg;
    endproperty
    a_seg: assert property (p_seg) else $error("vector segment mismatch");

    property p_spacing;
        grant_any && $stable(spc_reg)
            |-> grant_reg.addr[15:0] == 16'({9'h000, grant_reg.num} << (spc_reg + 3'd2));
    endproperty
    a_spacing: assert property (p_spacing) else $error("vector offset wrong");

    property p_default4;
        grant_any && spc_reg == 2'h0 && $past(spc_reg) == 2'h0
            |-> grant_reg.addr[15:0] == {7'h00, grant_reg.num, 2'b00};
    endproperty
    a_default4: assert property (p_default4) else $error("default spacing not 4");

    // node without a source: only a bus write may raise its request
    property p_no_source;
        !$past(node_wr) |-> !$rose(node_reg[HAS_SECOND_SERIAL ? 7'h58 : 7'h4A].req);
    endproperty
    a_no_source: assert property (p_no_source) else $error("sourceless node fired");

    property p_nmi;
        trap_cond_i[0] && !trap_busy |-> ##[1:3] grant_reg.trap && grant_reg.num == 7'h02;
    endproperty
    a_nmi: assert property (p_nmi) else $error("trap not presented");

    property p_tflag;
        |trap_cond_i |=> (tflag_reg & $past(trap_cond_i)) == $past(trap_cond_i);
    endproperty
    a_tflag: assert property (p_tflag) else $error("trap flag not set");

    property p_trap_block;
        trap_busy |-> !grant_reg.irq && !grant_reg.xfer;
    endproperty
    a_trap_block: assert property (p_trap_block) else $error("request during trap");

    property p_level;
        grant_reg.irq |-> $past(node_reg[grant_next.num].lvl) > $past(cpu_prio_i);
    endproperty
    a_level: assert property (p_level) else $error("level not above core");

    property p_sw_req;
        node_wr && node_idx == 7'h54 && wb_sel_i[0] && wb_dat_i[7] && !take_fire
            |=> node_reg[7'h54].req;
    endproperty
    a_sw_req: assert property (p_sw_req) else $error("software request lost");

    property p_xfer_cnt;
        take_xfer && !xfer_wr |=> cnt_reg[$past(grant_reg.chan)] == $past(take_cnt) - 8'h01;
    endproperty
    a_xfer_cnt: assert property (p_xfer_cnt) else $error("count not decremented");

    property p_clear;
        take_irq && !node_wr && !node_req_i[grant_reg.num]
            |=> !node_reg[$past(grant_reg.num)].req;
    endproperty
    a_clear: assert property (p_clear) else $error("request not cleared");

    c_trap: cover property (take_trap);
    c_xfer_last: cover property (xfer_last);
    c_irq_take: cover property (take_irq ##[1:20] grant_reg.irq);
endmodule

// File: test/ivt_core_model.sv
// core side model: takes presented grants and ends trap services
module ivt_core_model
    import ivt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input ivt_pkg::ivt_grant_t grant_i,
    input wire logic [3:0] dly_i,
    input wire logic done_req_i,
    output logic take_o,
    output logic trap_done_o
);
    // ---------------------------------------------------------
    // take after a programmable wait, prompt or slow
    // ---------------------------------------------------------
    logic [3:0] cnt_reg;
    logic shown;
    assign shown = grant_i.irq | grant_i.xfer | grant_i.trap;
    always_ff @(posedge clk_i) begin
        take_o <= 1'b0;
        trap_done_o <= done_req_i;
        if (rst_i) begin
            cnt_reg <= 4'h0;
            trap_done_o <= 1'b0;
        end else if (shown && !take_o) begin
            if (cnt_reg >= dly_i) begin
                take_o <= 1'b1;
                cnt_reg <= 4'h0;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
endmodule

// File: test/tb_top.sv
// self-checking bench for the vector and trap dispatcher
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ivt_pkg::*;
    // ---------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------
    logic clk_i, rst_i, cyc, stb, we, ack, irq, take, tdone, done_req;
    logic [11:0] adr;
    logic [3:0] sel, prio, dly;
    logic [31:0] wdat, rdat, q;
    logic [127:0] nreq;
    logic [7:0] tcond, seg;
    logic [1:0] spc;
    logic [6:0] n;
    logic [3:0] lv;
    ivt_grant_t grant;
    int failures = 0;
    int compares = 0;
    logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h7F0};

    ivt_dispatch i_ivt_dispatch (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .node_req_i(nreq), .trap_cond_i(tcond), .cpu_prio_i(prio),
        .take_i(take), .trap_done_i(tdone), .grant_o(grant), .irq_o(irq));
    ivt_core_model i_ivt_core_model (.clk_i(clk_i), .rst_i(rst_i), .grant_i(grant),
        .dly_i(dly), .done_req_i(done_req), .take_o(take), .trap_done_o(tdone));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ---------------------------------------------------------
    // tasks and expectations
    // ---------------------------------------------------------
    function automatic logic [23:0] exp_addr(logic [6:0] t);
        return {seg, 16'({9'h0, t}) << (2 + spc)};
    endfunction

    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do @(posedge clk_i); while (ack !== 1'b1 && ++k < 50);
        `CHK("ack", 1'b1, ack)
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic ctrl(input logic [6:0] t, input logic [3:0] l, input logic sw,
            input logic pe, input logic [2:0] ch);
        wb(1'b1, 12'h200 + {3'h0, t, 2'h0}, {20'h0, ch, pe, sw, 1'b1, 2'h0, l});
    endtask

    task automatic pulse(input logic [127:0] m, input logic [7:0] tc);
        @(posedge clk_i);
        nreq <= m; tcond <= tc;
        @(posedge clk_i);
        nreq <= '0; tcond <= 8'h00;
    endtask

    // kind: irq, transfer, trap
    task automatic serve(input logic [2:0] kind, input logic [6:0] t, input logic [2:0] ch);
        ivt_grant_t e, g;
        int k;
        e = '{irq: kind[2], xfer: kind[1], trap: kind[0], num: t, chan: ch, addr: exp_addr(t)};
        k = 0;
        do @(posedge clk_i); while (!(grant.irq | grant.xfer | grant.trap) && ++k < 40);
        g = grant;
        if (!kind[1]) g.chan = ch;
        `CHK("grant", e, g)
        k = 0;
        do @(posedge clk_i); while (take !== 1'b1 && ++k < 40);
        `CHK("take", 1'b1, take)
    endtask

    task automatic quiet(input int c);
        repeat (c) @(posedge clk_i);
        `CHK("no grant", ivt_grant_t'(0), grant)
    endtask

    task automatic results();
        $display("checks %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        results();
    end

    // ---------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------
    initial begin
        void'($urandom(57445));
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h0; sel = 4'h0;
        wdat = 32'h0; nreq = '0; tcond = 8'h00; prio = 4'h0; dly = 4'h2; done_req = 1'b0;
        seg = 8'h00; spc = 2'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ra[i]) begin
            wb(1'b0, ra[i], 32'h0);
            `CHK("reset value", 32'h0, q)
        end
        seg = 8'($urandom);
        wb(1'b1, 12'h000, {24'h0, seg});
        wb(1'b1, 12'h010, 32'h7);
        // default spacing, request clear on take, take event
        ctrl(7'h46, 4'h5, 1'b0, 1'b0, 3'h0);
        pulse(128'h1 << 7'h46, 8'h00);
        serve(3'b100, 7'h46, 3'h0);
        repeat (2) @(posedge clk_i);
        `CHK("irq line", 1'b1, irq)
        wb(1'b0, 12'h00C, 32'h0);
        `CHK("status", 32'h4, q)
        wb(1'b0, 12'h318, 32'h0);
        `CHK("node ctrl", 32'h45, q)
        repeat (3) @(posedge clk_i);
        `CHK("irq line", 1'b0, irq)
        // equal levels, then software request on unassigned node
        ctrl(7'h4D, 4'h4, 1'b0, 1'b0, 3'h0);
        ctrl(7'h46, 4'h4, 1'b0, 1'b0, 3'h0);
        pulse((128'h1 << 7'h4D) | (128'h1 << 7'h46), 8'h00);
        serve(3'b100, 7'h46, 3'h0);
        serve(3'b100, 7'h4D, 3'h0);
        ctrl(7'h54, 4'h2, 1'b1, 1'b0, 3'h0);
        serve(3'b100, 7'h54, 3'h0);
        // sourceless node ignores its line, built-in serial node is served
        ctrl(7'h58, 4'h3, 1'b0, 1'b0, 3'h0);
        pulse(128'h1 << 7'h58, 8'h00);
        quiet(4);
        ctrl(7'h4A, 4'h3, 1'b0, 1'b0, 3'h0);
        pulse(128'h1 << 7'h4A, 8'h00);
        serve(3'b100, 7'h4A, 3'h0);
        // strictly higher level only
        prio <= 4'h7;
        ctrl(7'h20, 4'h7, 1'b1, 1'b0, 3'h0);
        quiet(6);
        ctrl(7'h21, 4'h8, 1'b1, 1'b0, 3'h0);
        serve(3'b100, 7'h21, 3'h0);
        prio <= 4'h0;
        serve(3'b100, 7'h20, 3'h0);
        // traps: unmaskable, ordered, block nodes
        prio <= 4'hF;
        ctrl(7'h22, 4'h9, 1'b0, 1'b0, 3'h0);
        pulse(128'h1 << 7'h22, 8'h03);
        serve(3'b001, 7'h02, 3'h0);
        quiet(6);
        wb(1'b0, 12'h008, 32'h0);
        `CHK("trap flags", 32'h3, q)
        @(posedge clk_i) done_req <= 1'b1;
        @(posedge clk_i) done_req <= 1'b0;
        serve(3'b001, 7'h04, 3'h0);
        prio <= 4'h0;
        quiet(4);
        @(posedge clk_i) done_req <= 1'b1;
        @(posedge clk_i) done_req <= 1'b0;
        serve(3'b100, 7'h22, 3'h0);
        wb(1'b1, 12'h008, 32'h0);
        wb(1'b0, 12'h008, 32'h0);
        `CHK("trap flags", 32'h0, q)
        // event transfer channel with count one
        wb(1'b1, 12'h028, 32'h1);
        ctrl(7'h30, 4'h3, 1'b0, 1'b1, 3'h2);
        pulse(128'h1 << 7'h30, 8'h00);
        serve(3'b010, 7'h30, 3'h2);
        serve(3'b100, 7'h30, 3'h0);
        wb(1'b0, 12'h028, 32'h0);
        `CHK("count", 32'h0, q)
        wb(1'b0, 12'h00C, 32'h0);
        `CHK("status", 32'h7, q)
        // random nodes, levels, segments and spacings
        repeat (16) begin
            seg = 8'($urandom);
            spc = 2'($urandom);
            n = 7'h10 + 7'($urandom % 47);
            lv = 4'h1 + 4'($urandom % 15);
            dly <= 4'($urandom % 6);
            wb(1'b1, 12'h000, {24'h0, seg});
            wb(1'b1, 12'h004, {30'h0, spc});
            ctrl(n, lv, 1'b0, 1'b0, 3'h0);
            pulse(128'h1 << n, 8'h00);
            serve(3'b100, n, 3'h0);
        end
        results();
    end
endmodule
